// >>> verilog/cpu_if_config_protect_regs.sv
/*
 * Host-interface configuration registers: the two write-only DMA data ports,
 * the unlock key, the reference clock choice and the bus settings register,
 * plus the pin-level polarity of interrupt, request and acknowledge and the interrupt drive.
 * Assumes a same-clock byte register port, internal FIFO and DMA control
 * logic on the same clock, and pins that arrive asynchronously.
 */
// The plain strobed port was decided locally.
//
// Summary of operation
// - With DMA mode on, each byte written to a DMA data port enters the FIFO.
// - In 8-bit operation either DMA data port performs the same byte write.
// - Clock choice and bus settings accept writes only while key holds 56h.
// - Key and bus settings stay readable and writable during sleep.
// - Clock choice register stays functional and accessible during sleep.
// - The three shared registers appear at one offset in both port windows.
// - Clock choice bit 0 selects 12 MHz or 24 MHz; others reserved, reset 0.
// - Settings bit 7 sets interrupt polarity, 0 low active, 1 high active.
// - Settings bit 6 sets interrupt drive, both levels or active level only.
// - Settings bit 5 sets request output polarity, 0 low, 1 high active.
// - Settings bit 4 sets acknowledge input polarity; host drives it accordingly.
// - Settings bit 3 requires chip select with acknowledge for DMA access.
// - Settings bits 2 and 1 report byte swap and strobe style latched at init.
// - Settings bit 0 reads 1 once interface initialisation has completed.
`timescale 1ns/1ps
`default_nettype none

module cpu_if_config_protect_regs
(
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,

    // Register port.
    input wire logic [9:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,

    // State from neighbouring controller logic on the same clock.
    input wire logic dma_mode,
    input wire logic dma_dir_write,
    input wire logic bus_8bit,
    input wire logic sleep,
    input wire logic init_done,
    input wire logic init_byte_swap,
    input wire logic init_write_strobe_style,
    input wire logic irq_active,
    input wire logic dma_request,

    // FIFO area currently linked to the DMA channel.
    output logic fifo_wr_valid,
    output logic [7:0] fifo_wr_data,

    // Reference clock choice for the clock generator.
    output logic ref_clock_24m,

    // Pins.
    input wire logic chip_select_n,
    input wire logic transfer_ack_in,
    output logic irq_out_n,
    output logic irq_out_oe,
    output logic transfer_request_out,

    // Qualified DMA access seen on the pins, for the DMA control logic.
    output logic dma_access
);

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic ack_s1;
        logic ack_s2;
        logic [7:0] unlock_key;
        logic [7:0] ref_clock_choice;
        logic [7:0] bus_settings;
        logic [7:0] rdata;
        logic fifo_valid;
        logic [7:0] fifo_data;
        logic irq_level;
        logic irq_oe;
        logic req_level;
        logic dma_access;
    } state_s;

    logic [1:0] rst_sync_q;
    logic rst_n;
    state_s q;
    state_s d;

    // Reset is released through two flops so every state flop leaves reset together.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_sync_q <= 2'h0;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    logic [8:0] offs;
    logic unlocked;
    logic cs_active;
    logic ack_active;
    logic dma_cycle;
    logic dma_port_hit;

    always_comb
    begin
        d = q;

        // Both port windows decode the same offset bits.
        offs = reg_addr[8:0];
        unlocked = (q.unlock_key == cfg_protect_pkg::UNLOCK_VALUE);

        // Pins pass two flops; only the second one is used below.
        d.cs_s1 = chip_select_n;
        d.cs_s2 = q.cs_s1;
        d.ack_s1 = transfer_ack_in;
        d.ack_s2 = q.ack_s1;

        cs_active = !q.cs_s2;
        ack_active = q.bus_settings[cfg_protect_pkg::BIT_ACK_POLARITY] ?
            q.ack_s2 : !q.ack_s2;
        if (q.bus_settings[cfg_protect_pkg::BIT_CS_QUALIFY])
        begin
            dma_cycle = ack_active && cs_active;
        end
        else
        begin
            dma_cycle = ack_active;
        end
        d.dma_access = dma_cycle;

        // Even and odd ports behave alike whether the bus is 8 or 16 bits wide.
        dma_port_hit = (offs == cfg_protect_pkg::OFS_DMA_WRITE_EVEN) ||
            (offs == cfg_protect_pkg::OFS_DMA_WRITE_ODD);

        // Direction is trusted to the host; the FIFO path only needs DMA mode.
        d.fifo_valid = 1'b0;
        if (reg_wr && dma_mode && (dma_port_hit || q.dma_access))
        begin
            d.fifo_valid = 1'b1;
            d.fifo_data = reg_wdata;
        end

        // Sleep does not gate any of these registers.
        if (reg_wr && !dma_port_hit)
        begin
            if (offs == cfg_protect_pkg::OFS_UNLOCK_KEY)
            begin
                d.unlock_key = reg_wdata;
            end
            else if (offs == cfg_protect_pkg::OFS_REF_CLOCK)
            begin
                if (unlocked)
                begin
                    d.ref_clock_choice[cfg_protect_pkg::BIT_REF_CLOCK_24M] =
                        reg_wdata[cfg_protect_pkg::BIT_REF_CLOCK_24M];
                end
            end
            else if (offs == cfg_protect_pkg::OFS_BUS_SETTINGS)
            begin
                if (unlocked)
                begin
                    d.bus_settings[cfg_protect_pkg::CFG_RW_HI:cfg_protect_pkg::CFG_RW_LO] =
                        reg_wdata[cfg_protect_pkg::CFG_RW_HI:cfg_protect_pkg::CFG_RW_LO];
                end
            end
        end

        // Read-only fields follow the initialisation logic; the mode bits
        // freeze once initialisation is over.
        if (!init_done)
        begin
            d.bus_settings[cfg_protect_pkg::BIT_BYTE_SWAP] = init_byte_swap;
            d.bus_settings[cfg_protect_pkg::BIT_WRITE_STROBE_STYLE] =
                init_write_strobe_style;
        end
        d.bus_settings[cfg_protect_pkg::BIT_INIT_DONE] = init_done;

        // Read data stand for one cycle only; the DMA ports read as zero.
        d.rdata = cfg_protect_pkg::UNMAPPED_READ;
        if (reg_rd)
        begin
            if (offs == cfg_protect_pkg::OFS_UNLOCK_KEY)
            begin
                d.rdata = q.unlock_key;
            end
            else if (offs == cfg_protect_pkg::OFS_REF_CLOCK)
            begin
                d.rdata = q.ref_clock_choice;
            end
            else if (offs == cfg_protect_pkg::OFS_BUS_SETTINGS)
            begin
                d.rdata = q.bus_settings;
            end
            else
            begin
                d.rdata = cfg_protect_pkg::UNMAPPED_READ;
            end
        end

        // Interrupt pin: in open mode the pin is only driven while active.
        d.irq_level = q.bus_settings[cfg_protect_pkg::BIT_IRQ_POLARITY] ?
            irq_active : !irq_active;
        if (q.bus_settings[cfg_protect_pkg::BIT_IRQ_DRIVE_STYLE])
        begin
            d.irq_oe = irq_active;
        end
        else
        begin
            d.irq_oe = 1'b1;
        end

        d.req_level = q.bus_settings[cfg_protect_pkg::BIT_REQ_POLARITY] ?
            dma_request : !dma_request;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q.cs_s1 <= 1'b1;
            q.cs_s2 <= 1'b1;
            q.ack_s1 <= 1'b1;
            q.ack_s2 <= 1'b1;
            q.unlock_key <= cfg_protect_pkg::RST_UNLOCK_KEY;
            q.ref_clock_choice <= cfg_protect_pkg::RST_REF_CLOCK;
            q.bus_settings <= cfg_protect_pkg::RST_BUS_SETTINGS;
            q.rdata <= 8'h00;
            q.fifo_valid <= 1'b0;
            q.fifo_data <= 8'h00;
            q.irq_level <= 1'b1;
            q.irq_oe <= 1'b1;
            q.req_level <= 1'b1;
            q.dma_access <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;
    assign fifo_wr_valid = q.fifo_valid;
    assign fifo_wr_data = q.fifo_data;
    assign ref_clock_24m = q.ref_clock_choice[cfg_protect_pkg::BIT_REF_CLOCK_24M];
    assign irq_out_n = q.irq_level;
    assign irq_out_oe = q.irq_oe;
    assign transfer_request_out = q.req_level;
    assign dma_access = q.dma_access;

endmodule

`default_nettype wire

// >>> include/cfg_protect_pkg.sv
/*
 * Constants shared by the host-interface configuration and protection registers.
 * Assumes a byte-wide register port whose address carries the port-select bit at 9.
 */
`default_nettype none

package cfg_protect_pkg;

    // Register port geometry.
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int OFFS_W = 9;

    // Register offsets inside one port window; port 1 adds the port base.
    localparam logic [9:0] PORT1_BASE = 10'h200;
    localparam logic [8:0] OFS_DMA_WRITE_EVEN = 9'h06E;
    localparam logic [8:0] OFS_DMA_WRITE_ODD = 9'h06F;
    localparam logic [8:0] OFS_UNLOCK_KEY = 9'h071;
    localparam logic [8:0] OFS_REF_CLOCK = 9'h073;
    localparam logic [8:0] OFS_BUS_SETTINGS = 9'h075;

    // Unlock value and values after reset.
    localparam logic [7:0] UNLOCK_VALUE = 8'h56;
    localparam logic [7:0] RST_UNLOCK_KEY = 8'h56;
    localparam logic [7:0] RST_REF_CLOCK = 8'h00;
    localparam logic [7:0] RST_BUS_SETTINGS = 8'h01;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Field positions in the clock-choice register.
    localparam int BIT_REF_CLOCK_24M = 0;

    // Field positions in the bus-settings register.
    localparam int BIT_IRQ_POLARITY = 7;
    localparam int BIT_IRQ_DRIVE_STYLE = 6;
    localparam int BIT_REQ_POLARITY = 5;
    localparam int BIT_ACK_POLARITY = 4;
    localparam int BIT_CS_QUALIFY = 3;
    localparam int BIT_BYTE_SWAP = 2;
    localparam int BIT_WRITE_STROBE_STYLE = 1;
    localparam int BIT_INIT_DONE = 0;

    // Writable field span of the bus-settings register.
    localparam int CFG_RW_HI = 7;
    localparam int CFG_RW_LO = 3;

endpackage

`default_nettype wire

// >>> test/cfg_regs_asserts.sv
/* Checker for the configuration register block.
   Assumes it is bound to the top module's ports. */
`timescale 1ns/1ps
`default_nettype none
module cfg_regs_asserts
(
    // Clock, reset and register port.
    input wire logic clk,
    input wire logic resetn,
    input wire logic [9:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Neighbour state and outputs.
    input wire logic dma_mode,
    input wire logic irq_active,
    input wire logic dma_request,
    input wire logic fifo_wr_valid,
    input wire logic [7:0] fifo_wr_data,
    input wire logic ref_clock_24m,
    input wire logic irq_out_n,
    input wire logic irq_out_oe,
    input wire logic transfer_request_out
);
    // Shadows of the key and the guarded registers; any key write moves the key, only unlocked writes move the others.
    logic [7:0] key_q;
    logic [7:0] cfg_q;
    logic ck_q;
    logic open_w;
    assign open_w = key_q == cfg_protect_pkg::UNLOCK_VALUE;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            key_q <= cfg_protect_pkg::RST_UNLOCK_KEY;
            cfg_q <= cfg_protect_pkg::RST_BUS_SETTINGS;
            ck_q <= 1'b0;
        end
        else if (reg_wr)
        begin
            if (reg_addr[8:0] == cfg_protect_pkg::OFS_UNLOCK_KEY)
                key_q <= reg_wdata;
            if (open_w && reg_addr[8:0] == cfg_protect_pkg::OFS_BUS_SETTINGS)
                cfg_q <= reg_wdata;
            if (open_w && reg_addr[8:0] == cfg_protect_pkg::OFS_REF_CLOCK)
                ck_q <= reg_wdata[0];
        end
    end
    a_read_idle: assert property (@(posedge clk) disable iff (!resetn)
        !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
    a_fifo_cause: assert property (@(posedge clk) disable iff (!resetn)
        fifo_wr_valid |-> $past(reg_wr && dma_mode)) else $error("fifo write uncaused");
    a_fifo_data: assert property (@(posedge clk) disable iff (!resetn)
        fifo_wr_valid |-> fifo_wr_data == $past(reg_wdata)) else $error("fifo byte wrong");
    a_port_write: assert property (@(posedge clk) disable iff (!resetn)
        reg_wr && dma_mode && reg_addr[8:1] == 8'h37 |=> fifo_wr_valid)
        else $error("dma port write lost");
    a_ref_guard: assert property (@(posedge clk) disable iff (!resetn)
        $changed(ref_clock_24m) |-> ref_clock_24m == ck_q) else $error("clock choice moved");
    a_irq_level: assert property (@(posedge clk) disable iff (!resetn)
        irq_out_n == ($past(irq_active) ^ !$past(cfg_q[7]))) else $error("irq level wrong");
    a_irq_drive: assert property (@(posedge clk) disable iff (!resetn)
        irq_out_oe == (!$past(cfg_q[6]) || $past(irq_active))) else $error("irq drive wrong");
    a_req_level: assert property (@(posedge clk) disable iff (!resetn)
        transfer_request_out == ($past(dma_request) ^ !$past(cfg_q[5])))
        else $error("request level wrong");
endmodule
bind cpu_if_config_protect_regs cfg_regs_asserts chk (.clk, .resetn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .dma_mode, .irq_active, .dma_request, .fifo_wr_valid,
    .fifo_wr_data, .ref_clock_24m, .irq_out_n, .irq_out_oe, .transfer_request_out);
`default_nettype wire

// >>> test/host_pins_model.sv
/* Host pin model: chip select and DMA acknowledge.
   Assumes the bench tells it the programmed polarity and mode. */
`timescale 1ns/1ps
`default_nettype none
module host_pins_model
(
    // Commands from the bench.
    input wire logic ack_high,
    input wire logic cs_mode,
    input wire logic want,
    // Pins.
    output logic chip_select_n,
    output logic transfer_ack_in
);
    assign transfer_ack_in = want ~^ ack_high;
    assign chip_select_n = !(want && cs_mode);
endmodule
`default_nettype wire

// >>> test/tb.sv
/* Bench for the configuration register block.
   Assumes the checker binds itself to the design. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, resetn, reg_wr, reg_rd, dma_mode, dma_dir_write, bus_8bit, sleep;
    logic init_done, init_byte_swap, init_write_strobe_style, irq_active, dma_request;
    logic ack_high, cs_mode, want, chip_select_n, transfer_ack_in, fifo_wr_valid;
    logic ref_clock_24m, irq_out_n, irq_out_oe, transfer_request_out, dma_access;
    logic [9:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, fifo_wr_data, got;
    int mismatches = 0, num_checks = 0, cycles = 0;
    cpu_if_config_protect_regs uut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .dma_mode, .dma_dir_write, .bus_8bit, .sleep, .init_done,
        .init_byte_swap, .init_write_strobe_style, .irq_active, .dma_request,
        .fifo_wr_valid, .fifo_wr_data, .ref_clock_24m, .chip_select_n, .transfer_ack_in,
        .irq_out_n, .irq_out_oe, .transfer_request_out, .dma_access);
    host_pins_model host (.ack_high, .cs_mode, .want, .chip_select_n, .transfer_ack_in);
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    // A write also reports the FIFO byte it caused, or zero.
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1 got = fifo_wr_valid ? fifo_wr_data : 8'h00;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic do_reset(input logic strobe);
        resetn <= 1'b0;
        init_done <= 1'b0;
        init_byte_swap <= 1'b1;
        init_write_strobe_style <= strobe;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        // Initialisation ends only after the internal reset has left, or no mode bit is caught.
        repeat (4) @(posedge clk);
        init_done <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    task automatic t_defaults(input logic [7:0] cfg);
        rd(10'h071, 8'h56);
        rd(10'h073, 8'h00);
        rd(10'h075, cfg);
        rd(10'h06E, 8'h00);
        rd(10'h1F0, 8'h00);
    endtask
    task automatic t_pins(input logic pol, input logic open);
        irq_active <= 1'b1;
        dma_request <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({6'h00, irq_out_n, irq_out_oe}, {6'h00, pol, 1'b1});
        chk({7'h00, transfer_request_out}, {7'h00, pol});
        irq_active <= 1'b0;
        dma_request <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({6'h00, irq_out_n, irq_out_oe}, {6'h00, !pol, !open});
    endtask
    task automatic t_ack(input logic e);
        want <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk({7'h00, dma_access}, {7'h00, e});
        want <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk({7'h00, dma_access}, 8'h00);
    endtask
    task automatic t_unlocked;
        wr(10'h273, 8'hFF);
        rd(10'h073, 8'h01);
        chk({7'h00, ref_clock_24m}, 8'h01);
        wr(10'h075, 8'hFF);
        ack_high <= 1'b1;
        cs_mode <= 1'b1;
        rd(10'h275, 8'hFD);
        t_pins(1'b1, 1'b1);
        t_ack(1'b1);
        cs_mode <= 1'b0;
        t_ack(1'b0);
    endtask
    task automatic t_locked;
        sleep <= 1'b1;
        wr(10'h071, 8'h00);
        rd(10'h271, 8'h00);
        wr(10'h073, 8'h00);
        wr(10'h275, 8'h00);
        rd(10'h073, 8'h01);
        rd(10'h075, 8'hFD);
        init_byte_swap <= 1'b0;
        wr(10'h071, 8'h56);
        // The pin follows the new polarity before the register does; chip select qualification, still set, keeps a false access away.
        ack_high <= 1'b0;
        wr(10'h075, 8'h00);
        rd(10'h075, 8'h05);
        sleep <= 1'b0;
        t_pins(1'b0, 1'b0);
        t_ack(1'b1);
    endtask
    task automatic t_dma;
        dma_mode <= 1'b1;
        wr(10'h06E, 8'hA5);
        chk(got, 8'hA5);
        wr(10'h26F, 8'h3C);
        chk(got, 8'h3C);
        dma_mode <= 1'b0;
        wr(10'h06F, 8'h77);
        chk(got, 8'h00);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Cut a hang short; the whole run needs well under a thousand cycles.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            mismatches++;
            give_verdict;
        end
    end
    initial
    begin
        {reg_wr, reg_rd, dma_mode, sleep, irq_active, dma_request} = 6'h00;
        {ack_high, cs_mode, want, init_write_strobe_style} = 4'h0;
        {resetn, init_done, init_byte_swap, bus_8bit} = 4'h7;
        dma_dir_write = 1'b1;
        reg_addr = 10'h000;
        reg_wdata = 8'h00;
        do_reset(1'b0);
        t_defaults(8'h05);
        t_unlocked;
        t_locked;
        t_dma;
        do_reset(1'b1);
        t_defaults(8'h07);
        give_verdict;
    end
endmodule
`default_nettype wire
